// ### src/pllc_pkg.sv
// Package: register map, field positions, reset values and loop constants
package pllc_pkg;

  // ************************************************************
  // Register indices; byte address is four times the index
  // ************************************************************
  localparam logic [5:0] PLLC_IDX_CONTROL    = 6'h1C;
  localparam logic [5:0] PLLC_IDX_BANDWIDTH  = 6'h1D;
  localparam logic [5:0] PLLC_IDX_MULTIPLIER = 6'h1E;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int PLLC_CTL_IRQ_EN   = 7;
  localparam int PLLC_CTL_FLAG     = 6;
  localparam int PLLC_CTL_POWER    = 5;
  localparam int PLLC_CTL_BASE_SEL = 4;
  localparam int PLLC_BW_AUTO      = 7;
  localparam int PLLC_BW_LOCK      = 6;
  localparam int PLLC_BW_ACQ       = 5;
  localparam int PLLC_MUL_N_LSB    = 4;
  localparam int PLLC_MUL_L_LSB    = 0;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] PLLC_CONTROL_RESET    = 8'h20;
  localparam logic [7:0] PLLC_BANDWIDTH_RESET  = 8'h00;
  localparam logic [7:0] PLLC_MULTIPLIER_RESET = 8'h11;

  // ************************************************************
  // Lock detector: window length in reference edges and thresholds
  // ************************************************************
  localparam logic [7:0] PLLC_WINDOW_EDGES = 8'h20;
  localparam logic [7:0] PLLC_LOCK_ENTER   = 8'h01;
  localparam logic [7:0] PLLC_LOCK_EXIT    = 8'h02;
  localparam logic [7:0] PLLC_TRK_ENTER    = 8'h02;
  localparam logic [7:0] PLLC_TRK_EXIT     = 8'h04;

  // Phase detector state
  typedef enum logic [1:0] {PLLC_PD_IDLE, PLLC_PD_UP, PLLC_PD_DOWN} pllc_pd_e;

endpackage

// ### src/pllc_top.sv
// PLL loop mode, divider, lock detector and register file behind Wishbone
`timescale 1ns/100ps
`default_nettype none

module pllc_top
  import pllc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // System integration
  input  wire logic        oscillator_enable_request,
  output logic             cpu_irq,
  // Crystal and VCO side
  input  wire logic        crystal_amp_input,
  output logic             crystal_amp_output,
  input  wire logic        vco_clock,
  output logic             pll_active,
  output logic             filter_tracking,
  output logic             pump_up,
  output logic             pump_down,
  // Derived clocks
  output logic             crystal_clock,
  output logic             loop_reference_clock,
  output logic             final_reference_clock,
  output logic             vco_feedback_clock,
  output logic             base_source_select,
  output logic             base_clock_out,
  output logic             bus_clock
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [3:0] eff_n(input logic [3:0] n);
    eff_n = (n == 4'h0) ? 4'h1 : n;
  endfunction

  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  // ************************************************************
  // Register state
  // ************************************************************
  logic       irq_en_reg;
  logic       pll_flag_reg;
  logic       pll_on_reg;
  logic       base_sel_reg;
  logic       auto_reg;
  logic       acq_sw_reg;
  logic [7:0] mult_reg;
  logic       lock_reg;
  logic       trk_reg;
  logic [3:0] mult_n;
  logic [3:0] mult_l;
  logic       acq_bit;

  assign mult_n  = mult_reg[PLLC_MUL_N_LSB +: 4];
  assign mult_l  = mult_reg[PLLC_MUL_L_LSB +: 4];
  assign acq_bit = auto_reg ? trk_reg : acq_sw_reg;

  // ************************************************************
  // Input synchronisers: a change counts once stages two and three agree
  // ************************************************************
  logic [2:0] xtal_sync_reg;
  logic [2:0] vco_sync_reg;
  logic       xtal_level_reg;
  logic       vco_level_reg;
  logic       xtal_rise;
  logic       vco_rise;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      xtal_sync_reg <= 3'h0;
      vco_sync_reg  <= 3'h0;
    end else begin
      xtal_sync_reg <= {xtal_sync_reg[1:0], crystal_amp_input};
      vco_sync_reg  <= {vco_sync_reg[1:0], vco_clock};
    end
  end

  assign xtal_rise = (xtal_sync_reg[1] == xtal_sync_reg[2]) && xtal_sync_reg[2] && !xtal_level_reg;
  assign vco_rise  = (vco_sync_reg[1] == vco_sync_reg[2]) && vco_sync_reg[2] && !vco_level_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      xtal_level_reg <= 1'b0;
      vco_level_reg  <= 1'b0;
    end else begin
      if (xtal_sync_reg[1] == xtal_sync_reg[2]) begin
        xtal_level_reg <= xtal_sync_reg[2];
      end
      if (vco_sync_reg[1] == vco_sync_reg[2]) begin
        vco_level_reg <= vco_sync_reg[2];
      end
    end
  end

  // ************************************************************
  // Crystal oscillator and reference path
  // ************************************************************
  logic osc_on;
  logic ref_rise;

  assign osc_on   = oscillator_enable_request;
  assign ref_rise = osc_on && xtal_rise;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      crystal_amp_output    <= 1'b0;
      crystal_clock         <= 1'b0;
      loop_reference_clock  <= 1'b0;
      final_reference_clock <= 1'b0;
    end else begin
      // Amplifier held quiet while the oscillator is not requested
      // Inverts the synchronised level, so the raw pin never reaches a flop's logic
      crystal_amp_output    <= osc_on && !xtal_level_reg;
      crystal_clock         <= osc_on && xtal_level_reg;
      loop_reference_clock  <= crystal_clock;
      final_reference_clock <= loop_reference_clock;
    end
  end

  // ************************************************************
  // PLL enable and modulo feedback divider
  // ************************************************************
  logic       pll_run;
  logic [3:0] div_cnt_reg;
  logic       fb_rise;

  assign pll_run = pll_on_reg && osc_on && (mult_l != 4'h0);
  assign fb_rise = pll_run && vco_rise && (div_cnt_reg == eff_n(mult_n) - 4'h1);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_cnt_reg        <= 4'h0;
      vco_feedback_clock <= 1'b0;
      pll_active         <= 1'b0;
    end else begin
      pll_active <= pll_run;
      if (!pll_run) begin
        div_cnt_reg        <= 4'h0;
        vco_feedback_clock <= 1'b0;
      end else begin
        if (vco_rise) begin
          div_cnt_reg <= fb_rise ? 4'h0 : div_cnt_reg + 4'h1;
        end
        // High for the first N/2 VCO cycles, rounded down, of each N-cycle period; with an effective N of 1 it follows the VCO level
        if (eff_n(mult_n) == 4'h1) begin
          vco_feedback_clock <= vco_level_reg;
        end else begin
          vco_feedback_clock <= (div_cnt_reg < (eff_n(mult_n) >> 1));
        end
      end
    end
  end

  // ************************************************************
  // Phase detector: earlier edge opens a pulse, the later one closes it
  // ************************************************************
  pllc_pd_e pd_state_reg;

  always_ff @(posedge core_clk) begin
    if (srst || !pll_run) begin
      pd_state_reg <= PLLC_PD_IDLE;
    end else begin
      case (pd_state_reg)
        PLLC_PD_IDLE: begin
          if (ref_rise && !fb_rise) begin
            pd_state_reg <= PLLC_PD_UP;
          end else if (fb_rise && !ref_rise) begin
            pd_state_reg <= PLLC_PD_DOWN;
          end
        end
        PLLC_PD_UP: begin
          if (fb_rise) begin
            pd_state_reg <= PLLC_PD_IDLE;
          end
        end
        PLLC_PD_DOWN: begin
          if (ref_rise) begin
            pd_state_reg <= PLLC_PD_IDLE;
          end
        end
        default: pd_state_reg <= PLLC_PD_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pump_up   <= 1'b0;
      pump_down <= 1'b0;
    end else begin
      pump_up   <= pll_run && (pd_state_reg == PLLC_PD_UP);
      pump_down <= pll_run && (pd_state_reg == PLLC_PD_DOWN);
    end
  end

  // ************************************************************
  // Lock detector over a window of reference edges
  // ************************************************************
  logic [7:0] win_cnt_reg;
  logic [7:0] fb_cnt_reg;
  logic [7:0] fb_total;
  logic [7:0] freq_err;
  logic       win_end;
  logic       lock_next;

  assign fb_total = fb_cnt_reg + {7'h00, fb_rise};
  assign freq_err = abs_diff(fb_total, PLLC_WINDOW_EDGES);
  assign win_end  = ref_rise && (win_cnt_reg == PLLC_WINDOW_EDGES - 8'h01);

  always_comb begin
    lock_next = lock_reg;
    if (!pll_run || !auto_reg) begin
      lock_next = 1'b0;
    end else if (win_end) begin
      if (freq_err <= PLLC_LOCK_ENTER) begin
        lock_next = 1'b1;
      end else if (freq_err > PLLC_LOCK_EXIT) begin
        lock_next = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || !pll_run) begin
      win_cnt_reg <= 8'h00;
      fb_cnt_reg  <= 8'h00;
    end else if (win_end) begin
      win_cnt_reg <= 8'h00;
      fb_cnt_reg  <= 8'h00;
    end else begin
      // Window paced by reference edges so detector speed tracks reference
      win_cnt_reg <= win_cnt_reg + {7'h00, ref_rise};
      fb_cnt_reg  <= fb_total;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lock_reg <= 1'b0;
      trk_reg  <= 1'b0;
    end else begin
      lock_reg <= lock_next;
      if (!pll_run || !auto_reg) begin
        trk_reg <= 1'b0;
      end else if (win_end) begin
        if (freq_err <= PLLC_TRK_ENTER) begin
          trk_reg <= 1'b1;
        end else if (freq_err > PLLC_TRK_EXIT) begin
          trk_reg <= 1'b0;
        end
      end
    end
  end

  // Filter mode: acquisition shows the bit clear, otherwise tracking
  always_ff @(posedge core_clk) begin
    if (srst) begin
      filter_tracking <= 1'b0;
    end else begin
      filter_tracking <= pll_run && acq_bit;
    end
  end

  // ************************************************************
  // Wishbone slave: one wait state, ack for one cycle
  // ************************************************************
  logic       wb_req;
  logic       wb_done;
  logic       wr_ctl;
  logic       wr_bw;
  logic       wr_mul;
  logic       rd_ctl;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;

  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_done = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign wr_byte = wb_dat_i[7:0];
  assign wr_ctl  = wb_done && wb_we_i && wb_sel_i[0] && (wb_adr_i[7:2] == PLLC_IDX_CONTROL);
  assign wr_bw   = wb_done && wb_we_i && wb_sel_i[0] && (wb_adr_i[7:2] == PLLC_IDX_BANDWIDTH);
  assign wr_mul  = wb_done && wb_we_i && wb_sel_i[0] && (wb_adr_i[7:2] == PLLC_IDX_MULTIPLIER);
  assign rd_ctl  = wb_done && !wb_we_i && (wb_adr_i[7:2] == PLLC_IDX_CONTROL);

  always_comb begin
    rd_byte = 8'h00;
    case (wb_adr_i[7:2])
      PLLC_IDX_CONTROL: begin
        rd_byte[PLLC_CTL_IRQ_EN]   = irq_en_reg && auto_reg;
        rd_byte[PLLC_CTL_FLAG]     = pll_flag_reg && auto_reg;
        rd_byte[PLLC_CTL_POWER]    = pll_on_reg;
        rd_byte[PLLC_CTL_BASE_SEL] = base_sel_reg;
      end
      PLLC_IDX_BANDWIDTH: begin
        rd_byte[PLLC_BW_AUTO] = auto_reg;
        rd_byte[PLLC_BW_LOCK] = lock_reg;
        rd_byte[PLLC_BW_ACQ]  = acq_bit;
      end
      PLLC_IDX_MULTIPLIER: rd_byte = mult_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ************************************************************
  // Software-written control bits
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_en_reg   <= PLLC_CONTROL_RESET[PLLC_CTL_IRQ_EN];
      pll_on_reg   <= PLLC_CONTROL_RESET[PLLC_CTL_POWER];
      base_sel_reg <= PLLC_CONTROL_RESET[PLLC_CTL_BASE_SEL];
      auto_reg     <= PLLC_BANDWIDTH_RESET[PLLC_BW_AUTO];
      acq_sw_reg   <= PLLC_BANDWIDTH_RESET[PLLC_BW_ACQ];
      mult_reg     <= PLLC_MULTIPLIER_RESET;
    end else begin
      if (wr_ctl) begin
        // Enable cannot be written in manual mode
        if (auto_reg) begin
          irq_en_reg <= wr_byte[PLLC_CTL_IRQ_EN];
        end
        // Power cannot be written while the VCO drives the base clock
        if (!base_sel_reg) begin
          pll_on_reg <= wr_byte[PLLC_CTL_POWER];
        end
        // Selection only with power already on; one write can still set it while clearing power
        if (pll_on_reg && (mult_l != 4'h0)) begin
          base_sel_reg <= wr_byte[PLLC_CTL_BASE_SEL];
        end
      end else if (mult_l == 4'h0) begin
        base_sel_reg <= 1'b0;
      end
      if (wr_bw) begin
        auto_reg <= wr_byte[PLLC_BW_AUTO];
        if (!auto_reg) begin
          acq_sw_reg <= wr_byte[PLLC_BW_ACQ];
        end
      end
      if (wr_mul) begin
        mult_reg <= wr_byte;
      end
    end
  end

  // ************************************************************
  // Lock-change flag and interrupt request
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pll_flag_reg <= 1'b0;
    end else if (auto_reg && (lock_next != lock_reg)) begin
      pll_flag_reg <= 1'b1; // set beats a same-cycle read clear
    end else if (rd_ctl || !auto_reg) begin
      pll_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cpu_irq <= 1'b0;
    end else begin
      cpu_irq <= pll_flag_reg && irq_en_reg && auto_reg;
    end
  end

  // ************************************************************
  // Base clock and bus clock from the selected source
  // ************************************************************
  logic src_rise;

  assign src_rise = base_sel_reg ? (pll_run && vco_rise) : ref_rise;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      base_source_select <= 1'b0;
      base_clock_out     <= 1'b0;
      bus_clock          <= 1'b0;
    end else begin
      base_source_select <= base_sel_reg;
      if (src_rise) begin
        base_clock_out <= !base_clock_out;
        // Bus clock toggles on each base rise: a quarter of the source
        if (!base_clock_out) begin
          bus_clock <= !bus_clock;
        end
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_irq_cause: assert property (cpu_irq |-> $past(pll_flag_reg && irq_en_reg && auto_reg))
    else $error("interrupt without enabled flag");
  a_manual_quiet: assert property (!$past(auto_reg) |-> !cpu_irq && !lock_reg)
    else $error("manual mode shows lock or interrupt");
  a_flag_toggle: assert property ($past(auto_reg) && $changed(lock_reg) |-> pll_flag_reg)
    else $error("lock toggled without flag");
  a_range_zero: assert property ((mult_l == 4'h0) |=> !pll_active && !base_sel_reg)
    else $error("zero range left pll running");
  a_filter_mode: assert property (filter_tracking |-> $past(pll_run && acq_bit))
    else $error("tracking without cause");
  a_pump_excl: assert property (!(pump_up && pump_down))
    else $error("both pump pulses high");
  a_osc_gate: assert property (!$past(osc_on) |-> !crystal_amp_output && !crystal_clock)
    else $error("oscillator runs without request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over two cycles");
  a_lock_window: assert property ($rose(lock_reg) |-> $past(win_end))
    else $error("lock set outside window end");

  c_lock_gain: cover property ($rose(lock_reg));
  c_irq_raise: cover property ($rose(cpu_irq));
  c_vco_base: cover property ($rose(base_sel_reg));
  c_lock_loss: cover property ($fell(lock_reg) && auto_reg);

endmodule

`default_nettype wire

// ### verification/pll_loop_mode_and_lock_control_test.sv
// Self-checking bench: register model, loop scenarios and report
`timescale 1ns/100ps
`default_nettype none
module pll_loop_mode_and_lock_control_test;
  import pllc_pkg::*;
  logic        core_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        osc_en, x_in, x_out, vco, pll_active, trk, cpu_irq, bsel;
  logic        bus_clk, fb_clk, ref_clk, probe_sig;
  logic        xtal_clk, lref_clk, base_clk, p_up, p_dn;
  logic [7:0]  wb_adr_i, m_mul;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] vco_half;
  bit          m_ie, m_pw, m_bs, m_auto, m_acq, m_lock, m_trk;
  int          bad_count, cmp_count, cyc_n, p_sel;

  assign probe_sig = (p_sel == 0) ? bus_clk : (p_sel == 1) ? fb_clk :
                     (p_sel == 2) ? ref_clk : (p_sel == 3) ? base_clk :
                     (p_sel == 4) ? xtal_clk : lref_clk;
  always #50 core_clk = ~core_clk;

  pllc_top uut (
    .core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .oscillator_enable_request(osc_en),
    .cpu_irq(cpu_irq), .crystal_amp_input(x_in), .crystal_amp_output(x_out),
    .vco_clock(vco), .pll_active(pll_active), .filter_tracking(trk), .pump_up(p_up),
    .pump_down(p_dn), .crystal_clock(xtal_clk), .loop_reference_clock(lref_clk),
    .final_reference_clock(ref_clk), .vco_feedback_clock(fb_clk),
    .base_source_select(bsel), .base_clock_out(base_clk), .bus_clock(bus_clk));

  pllc_xtal_model xtal (.ring(osc_en), .xtal_out(x_in), .vco_run(pll_active),
    .vco_half_ns(vco_half), .vco_out(vco));

  // ********************************
  // Register model and bus tasks
  // ********************************
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // Model applies the interlocks with the values from before the write
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bit          t;
    t = m_bs;
    if (idx == PLLC_IDX_CONTROL) begin
      if (m_auto) m_ie = d[7];
      if (m_pw && m_mul[3:0] != 4'h0) m_bs = d[4];
      if (!t) m_pw = d[5];
    end else if (idx == PLLC_IDX_BANDWIDTH) begin
      if (!m_auto) m_acq = d[5];
      m_auto = d[7];
    end else if (idx == PLLC_IDX_MULTIPLIER) begin
      m_mul = d;
      if (d[3:0] == 4'h0) m_bs = 1'b0;
    end
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] m, input logic [7:0] e,
                    input string w);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(w, {24'h000000, e & m}, q & {24'hFFFFFF, m});
  endtask

  function automatic logic [7:0] e_ctl(input bit f);
    return {m_ie & m_auto, f & m_auto, m_pw, m_bs, 4'h0};
  endfunction

  function automatic logic [7:0] e_bw();
    return {m_auto, m_lock & m_auto, m_auto ? m_trk : m_acq, 5'h00};
  endfunction

  task automatic settle();
    repeat (2) @(posedge core_clk);
  endtask

  // Rising edges of the probe over 1600 cycles, one edge of phase slack
  task automatic rate(input int e, input string w);
    int   n;
    logic p;
    n = 0;
    p = probe_sig;
    repeat (1600) begin
      @(posedge core_clk);
      if (probe_sig && !p) n++;
      p = probe_sig;
    end
    check(w, e, (n >= e - 1 && n <= e + 1) ? e : n);
  endtask

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      bad_count++;
      stop_test();
    end
  end

  // ********************************
  // Scenarios
  // ********************************
  initial begin
    logic [7:0] d;
    logic       hit;
    logic       hup;
    core_clk = 1'b0;
    srst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    osc_en = 1'b1;
    vco_half = 16'h00FA;
    m_pw = 1'b1;
    m_mul = PLLC_MULTIPLIER_RESET;
    void'($urandom(32'hCFD178C8));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    rd(PLLC_IDX_CONTROL, 8'hF0, e_ctl(1'b0), "control reset");
    rd(PLLC_IDX_BANDWIDTH, 8'hFF, e_bw(), "bandwidth reset");
    rd(PLLC_IDX_MULTIPLIER, 8'hFF, m_mul, "multiplier reset");
    rd(6'h10, 8'hFF, 8'h00, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(PLLC_IDX_MULTIPLIER, d);
      rd(PLLC_IDX_MULTIPLIER, 8'hFF, m_mul, "multiplier");
    end
    wr(PLLC_IDX_MULTIPLIER, 8'h40);
    wr(PLLC_IDX_CONTROL, 8'h30);
    settle();
    check("active at L zero", 1'b0, pll_active);
    rd(PLLC_IDX_CONTROL, 8'hF0, e_ctl(1'b0), "base at L zero");
    wr(PLLC_IDX_MULTIPLIER, 8'h47);
    p_sel = 0;
    rate(20, "bus clock");
    p_sel = 1;
    rate(80, "feedback clock");
    p_sel = 2;
    rate(80, "final reference");
    p_sel = 3;
    rate(40, "base clock");
    p_sel = 4;
    rate(80, "crystal clock");
    p_sel = 5;
    rate(80, "loop reference");
    $display("test multiplier done");
    wr(PLLC_IDX_BANDWIDTH, 8'h80);
    wr(PLLC_IDX_CONTROL, 8'hA0);
    {m_lock, m_trk} = 2'b11;
    repeat (1920) @(posedge core_clk);
    rd(PLLC_IDX_BANDWIDTH, 8'hFF, e_bw(), "locked");
    check("tracking", 1'b1, trk);
    check("irq on lock", 1'b1, cpu_irq);
    rd(PLLC_IDX_CONTROL, 8'hF0, e_ctl(1'b1), "flag set");
    rd(PLLC_IDX_CONTROL, 8'hF0, e_ctl(1'b0), "flag cleared");
    settle();
    check("irq cleared", 1'b0, cpu_irq);
    wr(PLLC_IDX_BANDWIDTH, 8'hA0);
    rd(PLLC_IDX_BANDWIDTH, 8'hFF, e_bw(), "acq read only");
    wr(PLLC_IDX_CONTROL, 8'hB0);
    settle();
    check("base select", 1'b1, bsel);
    vco_half <= 16'h00C8;
    {m_lock, m_trk} = 2'b00;
    repeat (1280) @(posedge core_clk);
    // Feedback now runs faster than the reference, so only down pulses remain
    {hit, hup} = 2'b00;
    repeat (640) begin
      @(posedge core_clk);
      hit = hit | p_dn;
      hup = hup | p_up;
    end
    check("pump down", 1'b1, hit);
    check("pump up", 1'b0, hup);
    rd(PLLC_IDX_BANDWIDTH, 8'hFF, e_bw(), "lock lost");
    check("acquiring", 1'b0, trk);
    rd(PLLC_IDX_CONTROL, 8'hF0, e_ctl(1'b1), "flag on loss");
    wr(PLLC_IDX_CONTROL, 8'hA0);
    $display("test auto lock done");
    wr(PLLC_IDX_MULTIPLIER, 8'h07);
    vco_half <= 16'h03E8;
    {m_lock, m_trk} = 2'b11;
    repeat (1920) @(posedge core_clk);
    rd(PLLC_IDX_BANDWIDTH, 8'hFF, e_bw(), "N zero lock");
    $display("test N zero done");
    wr(PLLC_IDX_BANDWIDTH, 8'h20);
    rd(PLLC_IDX_BANDWIDTH, 8'hFF, e_bw(), "manual entry");
    settle();
    check("manual acq", 1'b0, trk);
    check("manual irq", 1'b0, cpu_irq);
    wr(PLLC_IDX_CONTROL, 8'h80);
    rd(PLLC_IDX_CONTROL, 8'hF0, e_ctl(1'b0), "manual control");
    wr(PLLC_IDX_CONTROL, 8'h20);
    repeat (640) @(posedge core_clk);
    wr(PLLC_IDX_BANDWIDTH, 8'h20);
    rd(PLLC_IDX_BANDWIDTH, 8'hFF, e_bw(), "manual track");
    settle();
    check("manual tracking", 1'b1, trk);
    repeat (640) @(posedge core_clk);
    wr(PLLC_IDX_CONTROL, 8'h30);
    settle();
    check("manual base", 1'b1, bsel);
    check("manual irq off", 1'b0, cpu_irq);
    $display("test manual done");
    osc_en <= 1'b0;
    repeat (20) @(posedge core_clk);
    hit = 1'b0;
    repeat (100) begin
      @(posedge core_clk);
      hit = hit | x_out;
    end
    check("amp idle", 1'b0, hit);
    check("pll stopped", 1'b0, pll_active);
    $display("test oscillator done");
    stop_test();
  end
endmodule
`default_nettype wire

// ### verification/pllc_xtal_model.sv
// Partner model: crystal and a VCO whose half period the bench sets
`timescale 1ns/100ps
`default_nettype none
module pllc_xtal_model (
  // Crystal side
  input  wire logic        ring,
  output logic             xtal_out,
  // VCO side
  input  wire logic        vco_run,
  input  wire logic [15:0] vco_half_ns,
  output logic             vco_out
);
  initial xtal_out = 1'b0;
  // A stopped crystal rests low rather than holding its last level
  always begin
    #1000;
    xtal_out = ring ? ~xtal_out : 1'b0;
  end
  // Guard keeps an unset half period from spinning at zero delay;
  // the 25 ns start offset keeps every VCO edge clear of the sampling edge
  initial begin
    vco_out = 1'b0;
    #25;
    forever begin
      if (vco_half_ns > 16'h0000) #(vco_half_ns);
      else #100;
      vco_out = vco_run ? ~vco_out : 1'b0;
    end
  end
endmodule
`default_nettype wire
